// ---- lem_device.sv ----
// device end: serial register slave, mode control, sticky status and channel gating
`timescale 1ns/1ps
`default_nettype none
module lem_device
  import lem_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  lem_if.device           link,
  input  wire logic       bus_select_drive_i,   // bus select pin driven (not floating)
  input  wire logic       overheat_i,
  input  wire logic       laser_rail_low_i,
  input  wire logic       overcurrent_i,
  input  wire logic       osc_fault_i,
  input  wire logic       cfg_timeout_i,
  input  wire logic       current_feedback_bad_i,
  output logic            channel_on_o,
  output logic            current_loop_mode_o,  // 1 current loop, 0 power loop
  output logic            standby_o,
  output logic [7:0]      active_control_o
);

  // two-flop synchronisers for link, standby, enable, bus select and feedback pins
  logic [7:0] sy_ff, nxt_sy;
  logic [7:0] pin_raw;
  assign pin_raw = {current_feedback_bad_i, bus_select_drive_i, overcurrent_i | overheat_i,
                    link.chan_enable_in, link.standby_n_pin, link.mosi, link.cs_n, link.sclk};
  logic [7:0] sa_ff;
  always_comb begin
    nxt_sy = sa_ff;
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // pin idle levels: deselected, awake, bus select driven; avoids a false wake edge
      sa_ff <= 8'h4A;
      sy_ff <= 8'h4A;
    end else begin
      sa_ff <= pin_raw;
      sy_ff <= nxt_sy;
    end
  end
  logic sclk_s, cs_n_s, mosi_s, stby_n_s, en_pin_s, bsel_ok_s, fb_bad_s;
  assign sclk_s    = sy_ff[0];
  assign cs_n_s    = sy_ff[1];
  assign mosi_s    = sy_ff[2];
  assign stby_n_s  = sy_ff[3];
  assign en_pin_s  = sy_ff[4];
  // R10 floating bus select flagged open
  assign bsel_ok_s = sy_ff[6];
  assign fb_bad_s  = sy_ff[7];

  // link state: edge detect, shift register, bit count, registers
  logic       sclk_d_ff, stby_d_ff;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] sh_ff, nxt_sh;
  logic [7:0] miso_sh_ff, nxt_miso_sh;
  logic [7:0] ev_ff, nxt_ev;
  logic       once_ff, nxt_once;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] act_ff, nxt_act;
  logic [7:0] mode_ff, nxt_mode;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] cs_prev_ff;
  logic       alert_ff, nxt_alert;
  logic       chan_ff, nxt_chan;
  logic       stby_ff, nxt_stby;
  logic [7:0] cs_val;
  logic       rise, fall, wake, op_mode, bad_mode, rd_ev, rd_cs;
  logic [6:0] addr;
  logic       rd_cs_pend_ff, nxt_rd_cs_pend;

  assign rise     = sclk_s & ~sclk_d_ff;
  assign fall     = ~sclk_s & sclk_d_ff;
  // R2 wake only on rising standby pin
  assign wake     = stby_n_s & ~stby_d_ff;
  // R3 illegal mode codes
  assign bad_mode = (mode_ff[1:0] != MODE_OPERATION) && (mode_ff[1:0] != MODE_CONFIG);
  assign op_mode  = (mode_ff[1:0] == MODE_OPERATION);
  assign cs_val   = {4'h0, fb_bad_s, en_pin_s, once_ff, chan_ff};

  function automatic logic [7:0] reg_read(input logic [6:0] a);
    case ({1'b0, a})
      ADDR_EVENT_FLAGS:  reg_read = ev_ff;
      ADDR_CHAN_STATE:   reg_read = cs_val;
      ADDR_CHAN_CONTROL: reg_read = ctrl_ff;
      ADDR_MODE_SELECT:  reg_read = mode_ff;
      ADDR_ERROR_MASK:   reg_read = mask_ff;
      default:           reg_read = 8'h00;
    endcase
  endfunction

  always_comb begin
    nxt_cnt     = cnt_ff;
    nxt_sh      = sh_ff;
    nxt_miso_sh = miso_sh_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_mode    = mode_ff;
    nxt_mask    = mask_ff;
    nxt_act     = act_ff;
    nxt_stby    = stby_ff;
    nxt_once    = once_ff;
    rd_ev       = 1'b0;
    rd_cs       = 1'b0;
    addr        = sh_ff[14:8];
    // R1 standby while pin low; registers untouched
    if (!stby_n_s)
      nxt_stby = 1'b1;
    else if (wake)
      nxt_stby = 1'b0;
    if (cs_n_s || stby_ff) begin
      nxt_cnt = 5'h00;
    end else begin
      if (rise) begin
        nxt_sh  = {sh_ff[14:0], mosi_s};
        nxt_cnt = cnt_ff + 5'h01;
        // after the 8th bit the address is known: load read data
        if (cnt_ff == 5'h07) begin
          nxt_miso_sh = reg_read({sh_ff[5:0], mosi_s});
          // R15 reading a status register acknowledges it
          rd_ev = sh_ff[6] && ({sh_ff[5:0], mosi_s} == ADDR_EVENT_FLAGS[6:0]);
          rd_cs = sh_ff[6] && ({sh_ff[5:0], mosi_s} == ADDR_CHAN_STATE[6:0]);
        end
      end else if (fall && cnt_ff >= 5'h09) begin
        // first read bit must stand through the fall that ends the address
        nxt_miso_sh = {miso_sh_ff[6:0], 1'b0};
      end
      if (cnt_ff == 5'(FRAME_BITS) && !sh_ff[15]) begin
        nxt_cnt = 5'h1F;  // write done, ignore rest of frame
        case ({1'b0, addr})
          // R6 configuration accepted only in configuration mode
          ADDR_CHAN_CONTROL: if (mode_ff[1:0] == MODE_CONFIG) nxt_ctrl = sh_ff[7:0];
          ADDR_MODE_SELECT:  nxt_mode = sh_ff[7:0];
          ADDR_ERROR_MASK:   nxt_mask = sh_ff[7:0];
          default: ;
        endcase
      end
    end
    // R4 operation mode makes the latch transparent
    // R5 configuration mode holds the active copy
    if (op_mode)
      nxt_act = ctrl_ff;
    if (chan_ff)
      nxt_once = 1'b1;
  end

  // R20 sticky flags, set wins over read clear
  always_comb begin
    nxt_ev = ev_ff;
    if (rd_ev)
      nxt_ev = 8'h00;
    // R17 wake sets core rail drop
    nxt_ev[EV_CORE_RAIL]   = nxt_ev[EV_CORE_RAIL] | wake;
    nxt_ev[EV_INTEGRITY]   = nxt_ev[EV_INTEGRITY] | bad_mode;
    nxt_ev[EV_OVERHEAT]    = nxt_ev[EV_OVERHEAT] | overheat_i;
    nxt_ev[EV_LASER_RAIL]  = nxt_ev[EV_LASER_RAIL] | laser_rail_low_i;
    nxt_ev[EV_OVERCURRENT] = nxt_ev[EV_OVERCURRENT] | overcurrent_i;
    nxt_ev[EV_OSC_FAULT]   = nxt_ev[EV_OSC_FAULT] | osc_fault_i;
    nxt_ev[EV_CFG_TIMEOUT] = nxt_ev[EV_CFG_TIMEOUT] | cfg_timeout_i;
  end

  // R7 R11 R18 R19 channel gate: errors pending or open input keep it off
  always_comb begin
    nxt_chan = op_mode && en_pin_s && !act_ff[CC_DISABLE] && !stby_ff &&
               bsel_ok_s && (ev_ff == 8'h00) && !rd_cs_pend_ff;
    // R12 alert on any unmasked status change
    nxt_alert = |((ev_ff ^ nxt_ev) & ~mask_ff) || (cs_val != cs_prev_ff);
  end

  // R16 power-on initial status read of 0x01 still pending
  assign nxt_rd_cs_pend = rd_cs_pend_ff & ~rd_cs;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_d_ff     <= 1'b0;
      stby_d_ff     <= 1'b1;
      cnt_ff        <= 5'h00;
      sh_ff         <= 16'h0000;
      miso_sh_ff    <= 8'h00;
      // R16 power-on flags set
      ev_ff         <= EVENT_FLAGS_RST;
      once_ff       <= 1'b0;
      // R8 R9 disable set, power loop selected
      ctrl_ff       <= CHAN_CONTROL_RST;
      act_ff        <= CHAN_CONTROL_RST;
      mode_ff       <= MODE_SELECT_RST;
      mask_ff       <= ERROR_MASK_RST;
      cs_prev_ff    <= 8'h00;
      alert_ff      <= 1'b0;
      chan_ff       <= 1'b0;
      stby_ff       <= 1'b0;
      rd_cs_pend_ff <= 1'b1;
    end else begin
      sclk_d_ff     <= sclk_s;
      stby_d_ff     <= stby_n_s;
      cnt_ff        <= nxt_cnt;
      sh_ff         <= nxt_sh;
      miso_sh_ff    <= nxt_miso_sh;
      ev_ff         <= nxt_ev;
      once_ff       <= nxt_once;
      ctrl_ff       <= nxt_ctrl;
      act_ff        <= nxt_act;
      mode_ff       <= nxt_mode;
      mask_ff       <= nxt_mask;
      cs_prev_ff    <= cs_val;
      alert_ff      <= nxt_alert;
      chan_ff       <= nxt_chan;
      stby_ff       <= nxt_stby;
      rd_cs_pend_ff <= nxt_rd_cs_pend;
    end
  end

  // R13 R14 read data leaves msb first
  assign link.miso           = miso_sh_ff[7];
  assign link.alert_n_pin    = ~alert_ff;
  assign channel_on_o        = chan_ff;
  assign current_loop_mode_o = act_ff[CC_LOOP_SELECT];
  assign standby_o           = stby_ff;
  assign active_control_o    = act_ff;

endmodule : lem_device
`default_nettype wire

// ---- lem_pkg.sv ----
// package: register map, field positions, reset values and states for the laser enable logic
// What this block does
// R1: standby pin low enters standby, RAM kept
// R2: standby left only on standby pin rising edge
// R3: mode codes 00 and 11 flag integrity error
// R4: mode 01 is operation mode, reset value
// R5: mode 10 configuration mode holds active settings
// R6: config writes only in configuration mode
// R7: channel needs operation mode, pin high, bit clear
// R8: disable bit is 0x10 bit 3, resets 1
// R9: 0x10 bit 0 selects loop, 0 power
// R10: floating bus select raises open-input error
// R11: open-input and pending errors disable channel
// R12: status changes pulse alert unless masked
// R13: status 0x00 holds the eight event flags
// R14: status 0x01 holds channel state flags
// R15: reading status acknowledges, channel stays off
// R16: power-on sets ram ready and rail drop
// R17: standby exit sets rail drop, keeps RAM
// R18: overcurrent or overheat disables channel
// R19: integrity error or config timeout disables channel
// R20: flags sticky, cleared by read, re-set if persisting
package lem_pkg;
  localparam logic [7:0] ADDR_EVENT_FLAGS   = 8'h00;
  localparam logic [7:0] ADDR_CHAN_STATE    = 8'h01;
  localparam logic [7:0] ADDR_CHAN_CONTROL  = 8'h10;
  localparam logic [7:0] ADDR_MODE_SELECT   = 8'h1C;
  localparam logic [7:0] ADDR_ERROR_MASK    = 8'h1D;

  // event_flags bit positions
  localparam int EV_RAM_READY     = 0;
  localparam int EV_CORE_RAIL     = 1;
  localparam int EV_INTEGRITY     = 2;
  localparam int EV_OVERHEAT      = 3;
  localparam int EV_LASER_RAIL    = 4;
  localparam int EV_OVERCURRENT   = 5;
  localparam int EV_OSC_FAULT     = 6;
  localparam int EV_CFG_TIMEOUT   = 7;
  // channel_state_flags bit positions
  localparam int CS_STATE         = 0;
  localparam int CS_ONCE          = 1;
  localparam int CS_ENABLE_PIN    = 2;
  localparam int CS_FEEDBACK_BAD  = 3;
  // channel_control bit positions
  localparam int CC_LOOP_SELECT   = 0;
  localparam int CC_DISABLE       = 3;

  localparam logic [7:0] CHAN_CONTROL_RST = 8'h08;
  localparam logic [1:0] MODE_OPERATION   = 2'h1;
  localparam logic [1:0] MODE_CONFIG      = 2'h2;
  localparam logic [7:0] MODE_SELECT_RST  = 8'h01;
  localparam logic [7:0] ERROR_MASK_RST   = 8'h00;
  localparam logic [7:0] EVENT_FLAGS_RST  = 8'h03;

  // serial frame: 1 r/w bit, 7 address bits, 8 data bits
  localparam int FRAME_BITS = 16;
  localparam int LINK_DIV   = 4;  // host link clock half period in clk cycles

  typedef enum logic [2:0] {
    LEM_H_IDLE = 3'b001,
    LEM_H_SHIFT = 3'b010,
    LEM_H_DONE = 3'b100
  } lem_host_state_e;
endpackage : lem_pkg

// ---- lem_if.sv ----
// interface: serial register link, standby and enable pins between host and device
`timescale 1ns/1ps
`default_nettype none
interface lem_if;
  logic sclk;      // link clock, made by the host
  logic cs_n;      // frame select, active low
  logic mosi;      // host to device data
  logic miso;      // device to host data
  logic standby_n_pin;
  logic chan_enable_in;
  logic alert_n_pin;

  modport device (
    input  sclk,
    input  cs_n,
    input  mosi,
    output miso,
    input  standby_n_pin,
    input  chan_enable_in,
    output alert_n_pin
  );
  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input  miso,
    output standby_n_pin,
    output chan_enable_in,
    input  alert_n_pin
  );
endinterface : lem_if
`default_nettype wire

// ---- lem_host.sv ----
// host end: makes the link clock, runs one 16-bit register frame per command
`timescale 1ns/1ps
`default_nettype none
module lem_host
  import lem_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  lem_if.host             link,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_read_i,
  input  wire logic [6:0] cmd_addr_i,
  input  wire logic [7:0] cmd_wdata_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_rdata_o,
  input  wire logic       standby_n_i,   // R2 host drives standby pin
  input  wire logic       chan_enable_i,
  output logic            alert_o
);

  lem_host_state_e st_ff, nxt_st;
  logic [15:0] sh_ff, nxt_sh;
  logic [7:0]  rd_ff, nxt_rd;
  logic [4:0]  bit_ff, nxt_bit;
  logic [3:0]  div_ff, nxt_div;
  logic        sclk_ff, nxt_sclk;
  logic        rv_ff, nxt_rv;
  logic [1:0]  al_ff;
  logic        miso_a_ff, miso_s_ff;

  // R6 R15 R16 R17 ordering of writes and status reads is software's job
  always_comb begin
    nxt_st   = st_ff;
    nxt_sh   = sh_ff;
    nxt_rd   = rd_ff;
    nxt_bit  = bit_ff;
    nxt_div  = div_ff;
    nxt_sclk = sclk_ff;
    nxt_rv   = 1'b0;
    case (st_ff)
      LEM_H_IDLE: if (cmd_valid_i) begin
        nxt_sh  = {cmd_read_i, cmd_addr_i, cmd_wdata_i};  // msb 1 marks a read
        nxt_bit = 5'h00;
        nxt_div = 4'h0;
        nxt_st  = LEM_H_SHIFT;
      end
      LEM_H_SHIFT: begin
        nxt_div = div_ff + 4'h1;
        if (div_ff == 4'(LINK_DIV - 1)) begin
          nxt_div  = 4'h0;
          nxt_sclk = ~sclk_ff;
          if (sclk_ff) begin
            // falling edge: next bit out, sample read data
            nxt_sh  = {sh_ff[14:0], 1'b0};
            nxt_bit = bit_ff + 5'h01;
            if (bit_ff >= 5'h08)
              nxt_rd = {rd_ff[6:0], miso_s_ff};
            if (bit_ff == 5'(FRAME_BITS - 1))
              nxt_st = LEM_H_DONE;
          end
        end
      end
      LEM_H_DONE: begin
        nxt_rv = 1'b1;
        nxt_st = LEM_H_IDLE;
      end
      default: nxt_st = LEM_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff     <= LEM_H_IDLE;
      sh_ff     <= 16'h0000;
      rd_ff     <= 8'h00;
      bit_ff    <= 5'h00;
      div_ff    <= 4'h0;
      sclk_ff   <= 1'b0;
      rv_ff     <= 1'b0;
      al_ff     <= 2'h3;
      miso_a_ff <= 1'b0;
      miso_s_ff <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      sh_ff     <= nxt_sh;
      rd_ff     <= nxt_rd;
      bit_ff    <= nxt_bit;
      div_ff    <= nxt_div;
      sclk_ff   <= nxt_sclk;
      rv_ff     <= nxt_rv;
      al_ff     <= {al_ff[0], link.alert_n_pin};
      miso_a_ff <= link.miso;
      miso_s_ff <= miso_a_ff;
    end
  end

  assign link.sclk           = sclk_ff;
  assign link.cs_n           = (st_ff != LEM_H_SHIFT);
  assign link.mosi           = sh_ff[15];
  assign link.standby_n_pin  = standby_n_i;
  assign link.chan_enable_in = chan_enable_i;
  assign cmd_ready_o         = (st_ff == LEM_H_IDLE);
  assign rsp_valid_o         = rv_ff;
  assign rsp_rdata_o         = rd_ff;
  assign alert_o             = ~al_ff[1];

endmodule : lem_host
`default_nettype wire

// ---- lem_sva.sv ----
// checker: link framing and alert pulse rules watched on the interface wires
`timescale 1ns/1ps
`default_nettype none
module lem_sva
  import lem_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic standby_n_pin,
  input wire logic chan_enable_in,
  input wire logic alert_n_pin
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic [4:0] rise_cnt_ff;
  logic [4:0] nxt_rise_cnt;
  logic       sclk_q_ff;

  // count link clock rises inside a frame, cleared while deselected
  always_comb begin
    nxt_rise_cnt = cs_n ? 5'h00 : rise_cnt_ff + {4'h0, (sclk & ~sclk_q_ff)};
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rise_cnt_ff <= 5'h00;
      sclk_q_ff   <= 1'b0;
    end else begin
      rise_cnt_ff <= nxt_rise_cnt;
      sclk_q_ff   <= sclk;
    end
  end

  property p_sclk_idle;  cs_n |-> !sclk; endproperty
  property p_frame_bits; $rose(cs_n) |-> rise_cnt_ff == 5'(FRAME_BITS); endproperty
  property p_frame_len;  $fell(cs_n) |-> ##[100:200] $rose(cs_n); endproperty
  property p_first_half; $fell(cs_n) |-> !sclk [*3]; endproperty
  property p_sclk_high;  $rose(sclk) |=> sclk [*3]; endproperty
  property p_sclk_low;   ($fell(sclk) && !cs_n) |=> !sclk [*3]; endproperty
  property p_mosi_setup; $rose(sclk) |-> $stable(mosi); endproperty
  property p_cs_gap;     $rose(cs_n) |=> cs_n; endproperty
  // changes in back-to-back cycles merge into one longer low stretch
  property p_alert_pulse; $fell(alert_n_pin) |=> ##[0:2] alert_n_pin; endproperty
  property p_alert_enable; $changed(chan_enable_in) |-> ##[1:6] !alert_n_pin; endproperty

  a_sclk_idle:   assert property (p_sclk_idle) else $error("link clock moved outside frame");
  a_frame_bits:  assert property (p_frame_bits) else $error("frame bit count wrong");
  a_frame_len:   assert property (p_frame_len) else $error("frame length out of range");
  a_first_half:  assert property (p_first_half) else $error("link clock early after select");
  a_sclk_high:   assert property (p_sclk_high) else $error("link clock high too short");
  a_sclk_low:    assert property (p_sclk_low) else $error("link clock low too short");
  a_mosi_setup:  assert property (p_mosi_setup) else $error("data moved at sampling edge");
  a_cs_gap:      assert property (p_cs_gap) else $error("frame select gap too short");
  a_alert_pulse: assert property (p_alert_pulse) else $error("alert low stretch too long");
  a_alert_enable: assert property (p_alert_enable) else $error("enable pin change not alerted");

  // main scenarios reached
  c_frame:   cover property ($rose(cs_n));
  c_alert:   cover property ($fell(alert_n_pin));
  c_wake:    cover property ($rose(standby_n_pin) && chan_enable_in);
endmodule // lem_sva
`default_nettype wire

// ---- laser_enable_mode_status_logic_bench.sv ----
// bench: host and device ends joined, register, channel, event and standby tests
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module laser_enable_mode_status_logic_bench;
  import lem_pkg::*;
  logic clk_i, nrst_i, bsel, fb, cv, cr, crd, rv, sn, ce, al, ch_on, loop, stby;
  logic [4:0] ev;
  logic [6:0] ca;
  logic [7:0] cw, rdat, actl, q;
  int         failures, num_checks;
  logic       al_seen, al_h_seen;
  int         pos [5] = '{EV_OVERHEAT, EV_LASER_RAIL, EV_OVERCURRENT, EV_OSC_FAULT, EV_CFG_TIMEOUT};
  lem_if lnk ();
  lem_device i_lem_device (.clk_i(clk_i), .nrst_i(nrst_i), .link(lnk), .bus_select_drive_i(bsel),
    .overheat_i(ev[0]), .laser_rail_low_i(ev[1]), .overcurrent_i(ev[2]), .osc_fault_i(ev[3]),
    .cfg_timeout_i(ev[4]), .current_feedback_bad_i(fb), .channel_on_o(ch_on),
    .current_loop_mode_o(loop), .standby_o(stby), .active_control_o(actl));
  lem_host i_lem_host (.clk_i(clk_i), .nrst_i(nrst_i), .link(lnk), .cmd_valid_i(cv),
    .cmd_ready_o(cr), .cmd_read_i(crd), .cmd_addr_i(ca), .cmd_wdata_i(cw), .rsp_valid_o(rv),
    .rsp_rdata_o(rdat), .standby_n_i(sn), .chan_enable_i(ce), .alert_o(al));
  lem_sva i_lem_sva (.clk_i(clk_i), .nrst_i(nrst_i), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .mosi(lnk.mosi), .miso(lnk.miso), .standby_n_pin(lnk.standby_n_pin),
    .chan_enable_in(lnk.chan_enable_in), .alert_n_pin(lnk.alert_n_pin));

  // clock generation
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // alert pin and host alert level seen since last clear; sampled off the launching edge
  always @(negedge clk_i) begin
    if (lnk.alert_n_pin === 1'b0) al_seen = 1'b1;
    if (al === 1'b1) al_h_seen = 1'b1;
  end

  // one register frame; waits for idle so a command is never refused
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    while (cr !== 1'b1 && n < 400) begin @(negedge clk_i); n++; end
    cv = 1'b1; crd = rd; ca = a[6:0]; cw = d;
    @(negedge clk_i);
    cv = 1'b0;
    while (rv !== 1'b1 && n < 800) begin @(negedge clk_i); n++; end
    q = rdat;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    xfer(1'b1, a, 8'h00);
    `CHK(nm, e, q)
  endtask
  task automatic settle();
    repeat (6) @(negedge clk_i);
  endtask

  task automatic t_reset();
    // power-on flags then read clears them
    rd_chk(ADDR_EVENT_FLAGS, EVENT_FLAGS_RST, "event flags at reset");
    rd_chk(ADDR_EVENT_FLAGS, 8'h00, "event flags after read");
    rd_chk(ADDR_CHAN_STATE, 8'h00, "channel state idle");
    rd_chk(ADDR_CHAN_CONTROL, CHAN_CONTROL_RST, "control reset");
    rd_chk(ADDR_MODE_SELECT, MODE_SELECT_RST, "mode reset");
    ce = 1'b1;
    settle();
    `CHK("channel blocked by disable bit", 1'b0, ch_on)
    $display("test reset done");
  endtask

  task automatic t_config();
    xfer(1'b0, ADDR_CHAN_CONTROL, 8'h01);
    rd_chk(ADDR_CHAN_CONTROL, CHAN_CONTROL_RST, "write in operation ignored");
    xfer(1'b0, ADDR_MODE_SELECT, {6'h00, MODE_CONFIG});
    xfer(1'b0, ADDR_CHAN_CONTROL, 8'h01);
    rd_chk(ADDR_CHAN_CONTROL, 8'h01, "config read back");
    `CHK("active held in config", CHAN_CONTROL_RST, actl)
    `CHK("loop held in config", 1'b0, loop)
    xfer(1'b0, ADDR_MODE_SELECT, {6'h00, MODE_OPERATION});
    settle();
    `CHK("active applied", 8'h01, actl)
    `CHK("current loop selected", 1'b1, loop)
    `CHK("channel on", 1'b1, ch_on)
    rd_chk(ADDR_CHAN_STATE, 8'h07, "channel state on");
    fb = 1'b1;
    rd_chk(ADDR_CHAN_STATE, 8'h0F, "feedback bad shown");
    fb = 1'b0;
    ce = 1'b0;
    settle();
    `CHK("pin low disables", 1'b0, ch_on)
    ce = 1'b1;
    settle();
    $display("test config done");
  endtask

  task automatic t_events();
    for (int i = 0; i < 5; i++) begin
      al_seen = 1'b0;
      al_h_seen = 1'b0;
      ev[i] = 1'b1;
      @(negedge clk_i);
      ev[i] = 1'b0;
      settle();
      `CHK("event disables", 1'b0, ch_on)
      `CHK("alert pulsed", 1'b1, al_seen)
      `CHK("host alert seen", 1'b1, al_h_seen)
      settle();
      `CHK("stays off until read", 1'b0, ch_on)
      rd_chk(ADDR_EVENT_FLAGS, 8'h01 << pos[i], "sticky event flag");
      settle();
      `CHK("on after acknowledge", 1'b1, ch_on)
    end
    $display("test events done");
  endtask

  task automatic t_faults();
    bsel = 1'b0;
    settle();
    `CHK("open bus select disables", 1'b0, ch_on)
    bsel = 1'b1;
    for (int c = 0; c < 4; c += 3) begin
      xfer(1'b0, ADDR_MODE_SELECT, 8'(c));
      settle();
      `CHK("illegal mode disables", 1'b0, ch_on)
      xfer(1'b1, ADDR_EVENT_FLAGS, 8'h00);
      `CHK("integrity flag", 1'b1, q[EV_INTEGRITY])
      xfer(1'b0, ADDR_MODE_SELECT, {6'h00, MODE_OPERATION});
      xfer(1'b1, ADDR_EVENT_FLAGS, 8'h00);
    end
    $display("test faults done");
  endtask

  task automatic t_standby();
    sn = 1'b0;
    settle();
    `CHK("standby entered", 1'b1, stby)
    sn = 1'b1;
    settle();
    `CHK("standby left on rise", 1'b0, stby)
    `CHK("off after wake", 1'b0, ch_on)
    rd_chk(ADDR_EVENT_FLAGS, 8'h01 << EV_CORE_RAIL, "rail drop on wake");
    rd_chk(ADDR_CHAN_CONTROL, 8'h01, "settings kept");
    settle();
    `CHK("on after wake read", 1'b1, ch_on)
    $display("test standby done");
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, about five times the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    $display("watchdog expired");
    summarize();
  end

  // main sequence
  initial begin
    nrst_i = 1'b0; bsel = 1'b1; fb = 1'b0; ev = 5'h00; cv = 1'b0; crd = 1'b0;
    ca = 7'h00; cw = 8'h00; sn = 1'b1; ce = 1'b0; al_seen = 1'b0; al_h_seen = 1'b0;
    repeat (8) @(negedge clk_i);
    nrst_i = 1'b1;
    t_reset();
    t_config();
    t_events();
    t_faults();
    t_standby();
    summarize();
  end
endmodule // laser_enable_mode_status_logic_bench
`default_nettype wire
